// ===== pkg/cse_defines.svh
// offsets, field positions, opcodes, status bit positions, busy bit and response codes
`ifndef CSE_DEFINES_SVH
`define CSE_DEFINES_SVH
// byte offsets on the register bus
`define CSE_OFF_INSTR   12'h000
`define CSE_OFF_ACC     12'h004
`define CSE_OFF_STATUS  12'h008
`define CSE_OFF_PC      12'h00C
`define CSE_OFF_PCLATCH 12'h010
`define CSE_OFF_STK_TOP 12'h014
`define CSE_OFF_WDT     12'h018
`define CSE_OFF_FILE    12'h200
// instruction word fields
`define CSE_OP_MSB      15
`define CSE_OP_LSB      12
`define CSE_DEST_BIT    10
`define CSE_BSEL_MSB    9
`define CSE_BSEL_LSB    7
// opcodes
`define CSE_OP_NOP      4'h0
`define CSE_OP_ADD_LIT  4'h1
`define CSE_OP_AND_LIT  4'h2
`define CSE_OP_ADD_FILE 4'h3
`define CSE_OP_AND_FILE 4'h4
`define CSE_OP_BCLR     4'h5
`define CSE_OP_BSET     4'h6
`define CSE_OP_SKIP_ONE 4'h7
`define CSE_OP_SKIP_ZRO 4'h8
`define CSE_OP_CLR_FILE 4'h9
`define CSE_OP_CLR_ACC  4'hA
`define CSE_OP_CALL     4'hB
`define CSE_OP_WDT_CLR  4'hC
// status register bit positions
`define CSE_ST_C        0
`define CSE_ST_HC       1
`define CSE_ST_Z        2
`define CSE_ST_PDN      3
`define CSE_ST_TMO      4
// instruction read-back busy bit
`define CSE_BUSY_BIT    31
// axi responses
`define CSE_RESP_OKAY   2'h0
`define CSE_RESP_DECERR 2'h3
`endif

// ===== pkg/cse_pkg.sv
// types shared by the subset executor modules
package cse_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} cse_state_t;
   typedef enum logic [3:0] {SEL_INSTR, SEL_ACC, SEL_STATUS, SEL_PC, SEL_PCLATCH,
                             SEL_STK_TOP, SEL_WDT, SEL_FILE, SEL_NONE} cse_sel_t;
   typedef struct packed {
      cse_state_t  st;
      logic [15:0] instr;
      logic [7:0]  acc;
      logic        c;
      logic        hc;
      logic        z;
      logic        pdn;
      logic        tmo;
      logic [12:0] pc;
      logic [4:0]  pclatch;
      logic [7:0]  wdt_cnt;
      logic [7:0]  wdt_pre;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } cse_core_t;
   typedef struct packed {
      logic [2:0]       ptr;
      logic [7:0][12:0] lvl;
   } cse_stack_t;
endpackage

// ===== pkg/cse_core_if.sv
// signals between the executor core, its alu and its return stack
`timescale 1ns/1ps
interface cse_core_if;
   logic [3:0]  op;
   logic [7:0]  acc;
   logic [7:0]  fval;
   logic [7:0]  lit;
   logic [2:0]  bsel;
   logic [7:0]  result;
   logic        cout;
   logic        dcout;
   logic        skip;
   logic        push;
   logic [12:0] push_val;
   logic [12:0] top;
   modport core (output op, acc, fval, lit, bsel, push, push_val,
                 input result, cout, dcout, skip, top);
   modport alu  (input op, acc, fval, lit, bsel, output result, cout, dcout, skip);
   modport stk  (input push, push_val, output top);
endinterface

// ===== hw/cse_alu.sv
// arithmetic, logic and bit-test unit
`timescale 1ns/1ps
`include "cse_defines.svh"
module cse_alu
   import cse_pkg::*;
(
   // operands and results
   cse_core_if.alu u
);
   logic [8:0] sum;
   logic [4:0] half;
   logic [7:0] opnd;

   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction

   always_comb begin
      opnd = (u.op == `CSE_OP_ADD_LIT || u.op == `CSE_OP_AND_LIT) ? u.lit : u.fval;
      // carry out of bit 7 and bit 3
      sum = {1'b0, u.acc} + {1'b0, opnd};
      half = {1'b0, u.acc[3:0]} + {1'b0, opnd[3:0]};
      u.cout = sum[8];
      u.dcout = half[4];
      u.skip = 1'b0;
      u.result = 8'h00;
      case (u.op)
         `CSE_OP_ADD_LIT, `CSE_OP_ADD_FILE: u.result = sum[7:0];
         `CSE_OP_AND_LIT, `CSE_OP_AND_FILE: u.result = u.acc & opnd;
         `CSE_OP_BCLR: u.result = u.fval & ~bit_mask(u.bsel);
         `CSE_OP_BSET: u.result = u.fval | bit_mask(u.bsel);
         // skip when tested bit is one
         `CSE_OP_SKIP_ONE: u.skip = |(u.fval & bit_mask(u.bsel));
         // skip when tested bit is zero
         `CSE_OP_SKIP_ZRO: u.skip = ~|(u.fval & bit_mask(u.bsel));
         default: u.result = 8'h00;
      endcase
   end
endmodule

// ===== hw/cse_stack.sv
// eight-level circular return stack
`timescale 1ns/1ps
`include "cse_defines.svh"
module cse_stack
   import cse_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // push port and top of stack
   cse_core_if.stk  s
);
   cse_stack_t r;
   cse_stack_t n;

   always_comb begin
      n = r;
      // push return address, ninth push overwrites the first
      if (s.push) begin
         n.lvl[r.ptr] = s.push_val;
         n.ptr = r.ptr + 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign s.top = r.lvl[r.ptr - 3'h1];
endmodule

// ===== hw/cse_core_exec.sv
// instruction subset executor with axi4-lite register access
`timescale 1ns/1ps
`include "cse_defines.svh"
module cse_core_exec
   import cse_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // write address channel
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // write data channel
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // write response channel
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // read address channel
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // read data channel
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   cse_core_t  r;
   cse_core_t  n;
   cse_core_if u ();
   logic [7:0] fmem [0:127];
   logic       mem_we;
   logic [6:0] mem_wa;
   logic [7:0] mem_wd;
   logic       wr_take;
   logic       rd_take;
   cse_sel_t   wsel;
   cse_sel_t   rsel;
   logic [3:0] op;
   logic [6:0] faddr;
   logic       dest;

   cse_alu   u_alu   (.u(u));
   cse_stack u_stack (.aclk(aclk), .aresetn(aresetn), .s(u));

   function automatic cse_sel_t decode(input logic [11:0] a);
      if (a == `CSE_OFF_INSTR) begin
         decode = SEL_INSTR;
      end else if (a == `CSE_OFF_ACC) begin
         decode = SEL_ACC;
      end else if (a == `CSE_OFF_STATUS) begin
         decode = SEL_STATUS;
      end else if (a == `CSE_OFF_PC) begin
         decode = SEL_PC;
      end else if (a == `CSE_OFF_PCLATCH) begin
         decode = SEL_PCLATCH;
      end else if (a == `CSE_OFF_STK_TOP) begin
         decode = SEL_STK_TOP;
      end else if (a == `CSE_OFF_WDT) begin
         decode = SEL_WDT;
      end else if (a[11:9] == 3'(`CSE_OFF_FILE >> 9) && a[1:0] == 2'h0) begin
         decode = SEL_FILE;
      end else begin
         decode = SEL_NONE;
      end
   endfunction

   assign op = r.instr[`CSE_OP_MSB:`CSE_OP_LSB];
   assign faddr = r.instr[6:0];
   assign dest = r.instr[`CSE_DEST_BIT];
   assign wsel = decode(s_axi_awaddr);
   assign rsel = decode(s_axi_araddr);
   // writes wait while an instruction is in flight
   assign wr_take = s_axi_awvalid && s_axi_wvalid && !r.bvalid && r.st == ST_IDLE;
   assign rd_take = s_axi_arvalid && !r.rvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = rd_take;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rdata = r.rdata;

   assign u.op = op;
   assign u.acc = r.acc;
   assign u.fval = fmem[faddr];
   assign u.lit = r.instr[7:0];
   assign u.bsel = r.instr[`CSE_BSEL_MSB:`CSE_BSEL_LSB];
   assign u.push = r.st == ST_EXEC && op == `CSE_OP_CALL;
   assign u.push_val = r.pc + 13'h0001;

   always_comb begin
      n = r;
      mem_we = 1'b0;
      mem_wa = faddr;
      mem_wd = 8'h00;
      // free-running watchdog, timeout drops on count wrap
      n.wdt_pre = r.wdt_pre + 8'h01;
      if (r.wdt_pre == 8'hFF) begin
         n.wdt_cnt = r.wdt_cnt + 8'h01;
         if (r.wdt_cnt == 8'hFF) begin
            n.tmo = 1'b0;
         end
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (wr_take) begin
         n.bvalid = 1'b1;
         n.bresp = (wsel == SEL_NONE) ? `CSE_RESP_DECERR : `CSE_RESP_OKAY;
         case (wsel)
            SEL_INSTR: begin
               if (s_axi_wstrb[1:0] == 2'h3) begin
                  n.instr = s_axi_wdata[15:0];
                  n.st = ST_EXEC;
               end
            end
            SEL_ACC: begin
               if (s_axi_wstrb[0]) begin
                  n.acc = s_axi_wdata[7:0];
               end
            end
            SEL_STATUS: begin
               if (s_axi_wstrb[0]) begin
                  n.c = s_axi_wdata[`CSE_ST_C];
                  n.hc = s_axi_wdata[`CSE_ST_HC];
                  n.z = s_axi_wdata[`CSE_ST_Z];
                  n.pdn = s_axi_wdata[`CSE_ST_PDN];
                  n.tmo = s_axi_wdata[`CSE_ST_TMO];
               end
            end
            SEL_PC: begin
               if (s_axi_wstrb[0]) begin
                  n.pc[7:0] = s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  n.pc[12:8] = s_axi_wdata[12:8];
               end
            end
            SEL_PCLATCH: begin
               if (s_axi_wstrb[0]) begin
                  n.pclatch = s_axi_wdata[4:0];
               end
            end
            SEL_FILE: begin
               mem_we = s_axi_wstrb[0];
               mem_wa = s_axi_awaddr[8:2];
               mem_wd = s_axi_wdata[7:0];
            end
            default: n.bresp = n.bresp;
         endcase
      end
      if (rd_take) begin
         n.rvalid = 1'b1;
         n.rresp = `CSE_RESP_OKAY;
         n.rdata = 32'h0000_0000;
         if (rsel == SEL_INSTR) begin
            n.rdata[15:0] = r.instr;
            n.rdata[`CSE_BUSY_BIT] = r.st != ST_IDLE;
         end else if (rsel == SEL_ACC) begin
            n.rdata[7:0] = r.acc;
         end else if (rsel == SEL_STATUS) begin
            n.rdata[4:0] = {r.tmo, r.pdn, r.z, r.hc, r.c};
         end else if (rsel == SEL_PC) begin
            n.rdata[12:0] = r.pc;
         end else if (rsel == SEL_PCLATCH) begin
            n.rdata[4:0] = r.pclatch;
         end else if (rsel == SEL_STK_TOP) begin
            n.rdata[12:0] = u.top;
         end else if (rsel == SEL_WDT) begin
            n.rdata[15:0] = {r.wdt_pre, r.wdt_cnt};
         end else if (rsel == SEL_FILE) begin
            n.rdata[7:0] = fmem[s_axi_araddr[8:2]];
         end else begin
            n.rresp = `CSE_RESP_DECERR;
         end
      end
      case (r.st)
         ST_IDLE: n.st = n.st;
         ST_EXEC: begin
            n.st = ST_IDLE;
            n.pc = r.pc + 13'h0001;
            case (op)
               `CSE_OP_ADD_LIT: begin
                  n.acc = u.result;
                  n.c = u.cout;
                  n.hc = u.dcout;
                  n.z = u.result == 8'h00;
               end
               `CSE_OP_AND_LIT: begin
                  n.acc = u.result;
                  n.z = u.result == 8'h00;
               end
               `CSE_OP_ADD_FILE, `CSE_OP_AND_FILE: begin
                  n.z = u.result == 8'h00;
                  if (op == `CSE_OP_ADD_FILE) begin
                     n.c = u.cout;
                     n.hc = u.dcout;
                  end
                  if (dest) begin
                     mem_we = 1'b1;
                     mem_wd = u.result;
                  end else begin
                     n.acc = u.result;
                  end
               end
               `CSE_OP_BCLR, `CSE_OP_BSET: begin
                  mem_we = 1'b1;
                  mem_wd = u.result;
               end
               `CSE_OP_SKIP_ONE, `CSE_OP_SKIP_ZRO: begin
                  // taken skip steps over and adds a nop cycle
                  if (u.skip) begin
                     n.pc = r.pc + 13'h0002;
                     n.st = ST_SECOND;
                  end
               end
               `CSE_OP_CLR_FILE: begin
                  mem_we = 1'b1;
                  mem_wd = 8'h00;
                  n.z = 1'b1;
               end
               `CSE_OP_CLR_ACC: begin
                  n.acc = 8'h00;
                  n.z = 1'b1;
               end
               // page bits from latch, two cycles
               `CSE_OP_CALL: begin
                  n.pc = {r.pclatch[4:3], r.instr[10:0]};
                  n.st = ST_SECOND;
               end
               `CSE_OP_WDT_CLR: begin
                  n.wdt_cnt = 8'h00;
                  n.wdt_pre = 8'h00;
                  n.tmo = 1'b1;
                  n.pdn = 1'b1;
               end
               default: n.st = ST_IDLE;
            endcase
         end
         ST_SECOND: n.st = ST_IDLE;
         default: n.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.tmo <= 1'b1;
         r.pdn <= 1'b1;
      end else begin
         r <= n;
      end
   end

   always_ff @(posedge aclk) begin
      if (mem_we) begin
         fmem[mem_wa] <= mem_wd;
      end
   end

   logic exec;
   assign exec = r.st == ST_EXEC;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence exec_skip_s;
      exec && (op == `CSE_OP_SKIP_ONE || op == `CSE_OP_SKIP_ZRO) && u.skip;
   endsequence
   sequence nop_then_idle_s;
      r.st == ST_SECOND ##1 r.st == ST_IDLE;
   endsequence

   add_lit_sum_a: assert property (
      exec && op == `CSE_OP_ADD_LIT |=> r.acc == 8'($past(r.acc) + $past(u.lit))
         && r.c == $past(u.cout) && r.z == (r.acc == 8'h00))
      else $error("add literal result or flags wrong");
   and_flags_a: assert property (
      exec && (op == `CSE_OP_AND_LIT || op == `CSE_OP_AND_FILE)
         |=> r.c == $past(r.c) && r.hc == $past(r.hc) && r.z == ($past(u.result) == 8'h00))
      else $error("and changed flags other than zero");
   dest_select_a: assert property (
      exec && (op == `CSE_OP_ADD_FILE || op == `CSE_OP_AND_FILE)
         |=> r.acc == ($past(dest) ? $past(r.acc) : $past(u.result))
         && (!$past(dest) || fmem[$past(faddr)] == $past(u.result)))
      else $error("destination bit not honoured");
   bit_flags_a: assert property (
      exec && (op == `CSE_OP_BCLR || op == `CSE_OP_BSET)
         |=> {r.c, r.hc, r.z, r.pdn} == $past({r.c, r.hc, r.z, r.pdn}))
      else $error("bit op changed status");
   bit_write_a: assert property (
      exec && (op == `CSE_OP_BCLR || op == `CSE_OP_BSET)
         |=> fmem[$past(faddr)][$past(u.bsel)] == ($past(op) == `CSE_OP_BSET))
      else $error("bit op did not force the selected bit");
   skip_nop_a: assert property (
      exec_skip_s |=> nop_then_idle_s)
      else $error("taken skip did not insert one nop cycle");
   clear_zero_a: assert property (
      exec && (op == `CSE_OP_CLR_FILE || op == `CSE_OP_CLR_ACC) |=> r.z)
      else $error("clear did not set zero");
   call_target_a: assert property (
      exec && op == `CSE_OP_CALL |=> r.pc == {$past(r.pclatch[4:3]), $past(r.instr[10:0])}
         && u.top == 13'($past(r.pc) + 13'h0001) ##1 r.st == ST_IDLE)
      else $error("call target or return address wrong");
   wdt_clear_a: assert property (
      exec && op == `CSE_OP_WDT_CLR |=> r.wdt_cnt == 8'h00 && r.tmo && r.pdn
         && r.z == $past(r.z) && r.c == $past(r.c))
      else $error("watchdog clear wrong");
   single_cycle_a: assert property (
      exec && op != `CSE_OP_CALL && !u.skip |=> r.st == ST_IDLE)
      else $error("instruction took more than one cycle");
   add_carry_a: assert property (
      exec && (op == `CSE_OP_ADD_LIT || op == `CSE_OP_ADD_FILE)
         |=> r.c == ($past(u.result) < $past(r.acc))
         && r.hc == ($past(u.result[3:0]) < $past(r.acc[3:0])))
      else $error("add carry or half carry wrong");
   clear_acc_a: assert property (
      exec && op == `CSE_OP_CLR_ACC |=> r.acc == 8'h00)
      else $error("clear accumulator left a value");
endmodule

// ===== sim/cse_core_exec_bench.sv
// self-checking bench for the subset executor over axi4-lite
`timescale 1ns/1ps
`include "cse_defines.svh"
module cse_core_exec_bench
   import cse_pkg::*;
;
   logic        aclk;
   logic        aresetn;
   logic [11:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [11:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   int          n_mismatch;
   int          checks;
   logic [31:0] v;
   logic [1:0]  r;

   cse_core_exec uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   always #4 aclk = ~aclk;

   task automatic report_and_stop();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
      end
   endtask

   // write with aw and w offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1 && wready === 1'b1) begin
            awvalid <= 1'b0;
            wvalid  <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            chk({30'h0, bresp}, {30'h0, er});
            break;
         end
         if (n > 200) begin
            chk(32'h0, 32'h1);
            break;
         end
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rr);
      int n;
      n = 0;
      d = 32'h0;
      rr = 2'h0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            rr = rresp;
            break;
         end
         if (n > 200) begin
            chk(32'h0, 32'h1);
            break;
         end
      end
      rready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  rr;
      rd(a, d, rr);
      chk(d, exp);
   endtask

   task automatic w(input logic [11:0] a, input logic [31:0] d);
      wr(a, d, 4'hF, `CSE_RESP_OKAY);
   endtask

   // issue one instruction, then poll until the core is idle again
   task automatic exec(input logic [15:0] ins);
      logic [31:0] d;
      logic [1:0]  rr;
      int          k;
      wr(`CSE_OFF_INSTR, {16'h0, ins}, 4'h3, `CSE_RESP_OKAY);
      k = 0;
      do begin
         rd(`CSE_OFF_INSTR, d, rr);
         k++;
      end while (d[`CSE_BUSY_BIT] !== 1'b0 && k < 10);
      chk({31'h0, d[`CSE_BUSY_BIT]}, 32'h0);
   endtask

   function automatic logic [11:0] fa(input int f);
      return `CSE_OFF_FILE + 12'(f * 4);
   endfunction

   function automatic logic [15:0] fi(input logic [3:0] op, input logic d,
                                      input logic [2:0] b, input logic [6:0] f);
      return {op, 1'b0, d, b, f};
   endfunction

   initial begin
      #160000;
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      n_mismatch = 0;
      checks = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`CSE_OFF_STATUS, 32'h18);
      rd_chk(`CSE_OFF_ACC, 32'h0);
      rd_chk(`CSE_OFF_PC, 32'h0);
      // literal add with wrap, then without carry
      w(`CSE_OFF_ACC, 32'hF8);
      exec({`CSE_OP_ADD_LIT, 4'h0, 8'h08});
      rd_chk(`CSE_OFF_ACC, 32'h00);
      rd_chk(`CSE_OFF_STATUS, 32'h1F);
      exec({`CSE_OP_ADD_LIT, 4'h0, 8'h7F});
      rd_chk(`CSE_OFF_ACC, 32'h7F);
      rd_chk(`CSE_OFF_STATUS, 32'h18);
      // literal and keeps carry and half carry
      w(`CSE_OFF_STATUS, 32'h1B);
      w(`CSE_OFF_ACC, 32'h5A);
      exec({`CSE_OP_AND_LIT, 4'h0, 8'hA5});
      rd_chk(`CSE_OFF_STATUS, 32'h1F);
      w(`CSE_OFF_ACC, 32'h3C);
      exec({`CSE_OP_AND_LIT, 4'h0, 8'h0F});
      rd_chk(`CSE_OFF_ACC, 32'h0C);
      rd_chk(`CSE_OFF_STATUS, 32'h1B);
      // file add to either destination
      w(fa(5), 32'h0F);
      w(`CSE_OFF_ACC, 32'h01);
      exec(fi(`CSE_OP_ADD_FILE, 1'b0, 3'h0, 7'd5));
      rd_chk(`CSE_OFF_ACC, 32'h10);
      rd_chk(fa(5), 32'h0F);
      rd_chk(`CSE_OFF_STATUS, 32'h1A);
      exec(fi(`CSE_OP_ADD_FILE, 1'b1, 3'h0, 7'd5));
      rd_chk(fa(5), 32'h1F);
      rd_chk(`CSE_OFF_ACC, 32'h10);
      w(fa(6), 32'h80);
      w(`CSE_OFF_ACC, 32'h80);
      exec(fi(`CSE_OP_ADD_FILE, 1'b1, 3'h0, 7'd6));
      rd_chk(fa(6), 32'h00);
      rd_chk(`CSE_OFF_STATUS, 32'h1D);
      // file and at the top file address
      w(fa(127), 32'hF0);
      w(`CSE_OFF_ACC, 32'h3C);
      exec(fi(`CSE_OP_AND_FILE, 1'b1, 3'h0, 7'd127));
      rd_chk(fa(127), 32'h30);
      rd_chk(`CSE_OFF_STATUS, 32'h19);
      w(`CSE_OFF_ACC, 32'h0F);
      exec(fi(`CSE_OP_AND_FILE, 1'b0, 3'h0, 7'd127));
      rd_chk(`CSE_OFF_ACC, 32'h00);
      rd_chk(`CSE_OFF_STATUS, 32'h1D);
      // every bit position set then cleared, flags untouched
      w(fa(7), 32'h00);
      w(`CSE_OFF_STATUS, 32'h05);
      for (int b = 0; b < 8; b++) begin
         exec(fi(`CSE_OP_BSET, 1'b0, 3'(b), 7'd7));
         rd_chk(fa(7), (2 << b) - 1);
      end
      for (int b = 0; b < 8; b++) begin
         exec(fi(`CSE_OP_BCLR, 1'b0, 3'(b), 7'd7));
         rd_chk(fa(7), (32'hFF << (b + 1)) & 32'hFF);
      end
      rd_chk(`CSE_OFF_STATUS, 32'h05);
      // both skips, taken and not taken, seen as pc step
      w(fa(9), 32'h80);
      for (int i = 0; i < 4; i++) begin
         w(`CSE_OFF_PC, 32'h100);
         exec(fi(i < 2 ? `CSE_OP_SKIP_ONE : `CSE_OP_SKIP_ZRO, 1'b0,
                 (i % 2 == 0) ? 3'h7 : 3'h0, 7'd9));
         rd_chk(`CSE_OFF_PC, (i == 0 || i == 3) ? 32'h102 : 32'h101);
      end
      rd_chk(`CSE_OFF_STATUS, 32'h05);
      // clearing a file register and the accumulator
      w(`CSE_OFF_STATUS, 32'h00);
      w(fa(3), 32'h55);
      exec(fi(`CSE_OP_CLR_FILE, 1'b0, 3'h0, 7'd3));
      rd_chk(fa(3), 32'h00);
      rd_chk(`CSE_OFF_STATUS, 32'h04);
      w(`CSE_OFF_STATUS, 32'h00);
      w(`CSE_OFF_ACC, 32'hAA);
      exec({`CSE_OP_CLR_ACC, 12'h0});
      rd_chk(`CSE_OFF_ACC, 32'h00);
      rd_chk(`CSE_OFF_STATUS, 32'h04);
      // calls with page values 3 and 0, the second return address wraps
      w(`CSE_OFF_PCLATCH, 32'h18);
      w(`CSE_OFF_PC, 32'h0123);
      exec({`CSE_OP_CALL, 1'b0, 11'h7FF});
      rd_chk(`CSE_OFF_PC, 32'h1FFF);
      rd_chk(`CSE_OFF_STK_TOP, 32'h0124);
      w(`CSE_OFF_PCLATCH, 32'h07);
      exec({`CSE_OP_CALL, 1'b0, 11'h005});
      rd_chk(`CSE_OFF_PC, 32'h0005);
      rd_chk(`CSE_OFF_STK_TOP, 32'h0000);
      // watchdog clear restarts the count and sets the two flags
      w(`CSE_OFF_STATUS, 32'h07);
      exec({`CSE_OP_WDT_CLR, 12'h0});
      rd(`CSE_OFF_WDT, v, r);
      chk(v & 32'hFF, 32'h0);
      chk({31'h0, v[15:8] < 8'h20}, 32'h1);
      rd_chk(`CSE_OFF_STATUS, 32'h1F);
      // refused and ignored accesses
      wr(12'h100, 32'h0, 4'hF, `CSE_RESP_DECERR);
      rd(12'h100, v, r);
      chk({30'h0, r}, {30'h0, `CSE_RESP_DECERR});
      w(`CSE_OFF_STK_TOP, 32'h1234);
      rd_chk(`CSE_OFF_STK_TOP, 32'h0000);
      w(`CSE_OFF_ACC, 32'h33);
      wr(`CSE_OFF_INSTR, {16'h0, `CSE_OP_CLR_ACC, 12'h0}, 4'h1, `CSE_RESP_OKAY);
      rd_chk(`CSE_OFF_ACC, 32'h33);
      // a no-operation only steps the program counter
      exec({`CSE_OP_NOP, 12'h0});
      rd_chk(`CSE_OFF_ACC, 32'h33);
      rd_chk(`CSE_OFF_PC, 32'h0007);
      report_and_stop();
   end
endmodule
